// ===== adc_serial_output_order_shutdown_tb.sv
`timescale 1ns/1ps

`define CHK(got, exp) begin checked++; if ((got) !== (exp)) begin bad_count++; \
  $display("[ERR] t=%0t got=%0h exp=%0h", $time, got, exp); end end

module adc_serial_output_order_shutdown_tb;
  import aso_pkg::*;

  logic        clock_i = 1'b0;
  logic        sys_rst_i = 1'b1;
  logic        cs_n, sclk, din, dout, dout_oe_n, system_off_n;
  logic        shutdown, conv_start, single_ended, odd_sign, unipolar;
  logic [1:0]  channel_sel;
  logic [11:0] result = 12'h000;
  int          checked = 0;
  int          bad_count = 0;
  int          starts = 0;
  int          tests = 0;

  // ****************************************************************
  // clock, design and host model
  // ****************************************************************
  always #4 clock_i = ~clock_i;

  always @(posedge clock_i) if (conv_start === 1'b1) starts <= starts + 1;

  aso_serial DUT (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .cs_n_i(cs_n), .sclk_i(sclk),
    .din_i(din), .result_i(result), .dout_o(dout), .dout_oe_n_o(dout_oe_n),
    .system_off_n_o(system_off_n), .shutdown_o(shutdown), .conv_start_o(conv_start),
    .single_ended_o(single_ended), .odd_sign_o(odd_sign), .channel_sel_o(channel_sel),
    .unipolar_o(unipolar));

  aso_host HOST (.clock_i(clock_i), .dout_i(dout), .dout_oe_n_i(dout_oe_n),
    .cs_n_o(cs_n), .sclk_o(sclk), .din_o(din));

  // ****************************************************************
  // expected stream, positions 1..n after the null bit
  // ****************************************************************
  function automatic logic [31:0] expect_bits(logic [11:0] res, logic [6:0] cmd, int n);
    logic [31:0] e;
    logic        b;
    e = '0;
    for (int p = 1; p <= n; p++) begin
      if (!cmd[FLD_POWER]) b = (p <= 12);
      else if (p <= 12) b = res[12-p];
      else if (cmd[FLD_ORDER]) b = 1'b0;
      else if (p <= 23) b = res[p-12];
      else b = !cmd[FLD_POLARITY] && res[11];
      e = {e[30:0], b};
    end
    return e;
  endfunction : expect_bits

  // one select cycle and its checks
  task automatic run(input logic [6:0] cmd, input logic [11:0] res, input int n);
    logic [31:0] got, oe;
    int          s0;
    result <= res;
    s0 = starts;
    HOST.frame(cmd, n, got, oe);
    `CHK(got, expect_bits(res, cmd, n))
    `CHK(oe, 32'h0)
    `CHK(dout_oe_n, 1'b1)
    `CHK(starts - s0, int'(cmd[FLD_POWER]))
    `CHK(shutdown, ~cmd[FLD_POWER])
    `CHK(system_off_n, cmd[FLD_POWER])
    `CHK({single_ended, odd_sign, channel_sel, unipolar}, cmd[6:2])
    tests++;
    $display("test %0d done", tests);
  endtask : run

  // verdict and end of run
  task automatic report_and_stop();
    $display("checked %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : report_and_stop

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    repeat (6) @(posedge clock_i);
    sys_rst_i <= 1'b0;
    repeat (8) @(posedge clock_i);
    `CHK(dout_oe_n, 1'b1)
    `CHK({shutdown, system_off_n}, 2'b01)
    run(7'b1011111, 12'hA5C, 16);
    run(7'b0100001, 12'h9C3, 26);
    run(7'b1110101, 12'h9C3, 25);
    run(7'b0001110, 12'h3FF, 16);
    repeat (100) @(posedge clock_i);
    `CHK({shutdown, system_off_n}, 2'b10)
    run(7'b1011110, 12'h000, 0);
    run(7'b1001011, 12'h5A5, 14);
    run(7'b0001110, 12'h000, 0);
    // reset in mid-run clears a standing shutdown
    sys_rst_i <= 1'b1;
    repeat (6) @(posedge clock_i);
    sys_rst_i <= 1'b0;
    repeat (8) @(posedge clock_i);
    `CHK({shutdown, system_off_n}, 2'b01)
    `CHK(dout_oe_n, 1'b1)
    tests++;
    $display("test %0d done", tests);
    run(7'b1011111, 12'h5A5, 13);
    report_and_stop();
  end
endmodule : adc_serial_output_order_shutdown_tb

// ===== aso_host.sv
`timescale 1ns/1ps

// ****************************************************************
// host side of the link, three port lines plus a read line
// ****************************************************************
module aso_host (
  input  wire logic clock_i,
  input  wire logic dout_i,
  input  wire logic dout_oe_n_i,
  output logic      cs_n_o,
  output logic      sclk_o,
  output logic      din_o
);
  // a released line reads as the inverse of the last driven bit
  logic dout_seen;
  assign dout_seen = dout_oe_n_i ? ~dout_i : dout_i;

  // idle: deselected, serial clock parked low
  initial begin
    cs_n_o = 1'b1;
    sclk_o = 1'b0;
    din_o  = 1'b0;
  end

  // wait a number of system clocks
  task automatic tick(input int n);
    repeat (n) @(posedge clock_i);
  endtask : tick

  // one select cycle: start bit, command, then n read bits
  task automatic frame(input logic [6:0] cmd, input int n,
                       output logic [31:0] bits, output logic [31:0] oe_n);
    logic [7:0] word;
    word = {1'b1, cmd};
    bits = '0;
    oe_n = '0;
    cs_n_o <= 1'b0;
    tick(6);
    for (int i = 7; i >= 0; i--) begin
      sclk_o <= 1'b0;
      din_o  <= word[i];
      tick(4);
      sclk_o <= 1'b1;
      tick(4);
    end
    // din toggles after the command, it must be ignored
    for (int i = 0; i < n; i++) begin
      sclk_o <= 1'b0;
      din_o  <= ~din_o;
      tick(4);
      sclk_o <= 1'b1;
      tick(3);
      bits = {bits[30:0], dout_seen};
      oe_n = {oe_n[30:0], dout_oe_n_i};
      tick(1);
    end
    // clock stands still once select is released
    sclk_o <= 1'b0;
    tick(4);
    cs_n_o <= 1'b1;
    tick(8);
  endtask : frame
endmodule : aso_host

// ===== aso_pkg.sv
package aso_pkg;

  // ****************************************************************
  // widths of the command and the result
  // ****************************************************************
  localparam int RES_BITS = 12;             // conversion result width
  localparam int CMD_BITS = 7;              // command bits after the start bit

  // ****************************************************************
  // command field positions, first received bit highest
  // ****************************************************************
  localparam int FLD_SINGLE   = 6;          // single-ended / differential
  localparam int FLD_ODD_SIGN = 5;          // odd / sign channel select
  localparam int FLD_SEL_HI   = 4;          // channel select high bit
  localparam int FLD_SEL_LO   = 3;          // channel select low bit
  localparam int FLD_POLARITY = 2;          // polarity_select_bit
  localparam int FLD_ORDER    = 1;          // output_order_bit
  localparam int FLD_POWER    = 0;          // power_down_bit

  // ****************************************************************
  // output stream positions, counted in host serial clocks
  // ****************************************************************
  localparam logic [4:0] POS_NULL    = 5'h00;  // null bit before the result
  localparam logic [4:0] POS_MSB_END = 5'h0C;  // last bit of msb-first word
  localparam logic [4:0] POS_LSB_END = 5'h17;  // last bit of lsb-first word
  localparam logic [4:0] POS_FILL    = 5'h18;  // fill from here on, saturates
  localparam logic [2:0] CNT_LAST    = 3'h7;   // count at the last command bit

  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic [6:0]  RST_CMD    = 7'h00;
  localparam logic [11:0] RST_RESULT = 12'h000;

  typedef enum logic [1:0] {
    ASO_IDLE,
    ASO_CMD,
    ASO_DATA
  } aso_state_t;

endpackage : aso_pkg

// ===== aso_serial.sv
`timescale 1ns/1ps

module aso_serial
  import aso_pkg::*;
(
  input  wire logic                clock_i,
  input  wire logic                sys_rst_i,
  input  wire logic                cs_n_i,
  input  wire logic                sclk_i,
  input  wire logic                din_i,
  input  wire logic [RES_BITS-1:0] result_i,
  output logic                     dout_o,
  output logic                     dout_oe_n_o,
  output logic                     system_off_n_o,
  output logic                     shutdown_o,
  output logic                     conv_start_o,
  output logic                     single_ended_o,
  output logic                     odd_sign_o,
  output logic [1:0]               channel_sel_o,
  output logic                     unipolar_o
);

  // ****************************************************************
  // pin synchronisers and edge detection
  // ****************************************************************
  logic [2:0] pin_s2;
  logic [2:0] pin_s3;
  logic       cs_lvl, sclk_lvl, din_lvl;
  logic       next_cs_lvl, next_sclk_lvl, next_din_lvl;
  logic       cs_fall, cs_rise, sclk_rise, sclk_fall;

  aso_sync #(.W(3)) u_sync (
    .clock_i  (clock_i),
    .sys_rst_i(sys_rst_i),
    .pin_i    ({~cs_n_i, sclk_i, din_i}),  // select inverted: cleared stages read idle
    .stage2_o (pin_s2),
    .stage3_o (pin_s3)
  );

  // a level counts once stages two and three agree; select comes in inverted
  always_comb begin
    next_cs_lvl   = (pin_s2[2] == pin_s3[2]) ? ~pin_s3[2] : cs_lvl;
    next_sclk_lvl = (pin_s2[1] == pin_s3[1]) ? pin_s3[1] : sclk_lvl;
    next_din_lvl  = (pin_s2[0] == pin_s3[0]) ? pin_s3[0] : din_lvl;
    cs_fall       = cs_lvl & ~next_cs_lvl;
    cs_rise       = ~cs_lvl & next_cs_lvl;
    sclk_rise     = ~sclk_lvl & next_sclk_lvl;
    sclk_fall     = sclk_lvl & ~next_sclk_lvl;
  end

  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cs_lvl   <= 1'b1;
      sclk_lvl <= 1'b0;
      din_lvl  <= 1'b0;
    end else begin
      cs_lvl   <= next_cs_lvl;
      sclk_lvl <= next_sclk_lvl;
      din_lvl  <= next_din_lvl;
    end
  end

  // ****************************************************************
  // output bit for a stream position
  // ****************************************************************
  function automatic logic bit_at(input logic [4:0]          pos,
                                  input logic [RES_BITS-1:0] res,
                                  input logic [6:0]          cmd,
                                  input logic                shut);
    logic bv;
    bv = 1'b0;
    if (shut) begin
      bv = (pos != POS_NULL) && (pos <= POS_MSB_END);
    end else if (pos == POS_NULL) begin
      bv = 1'b0;
    end else if (pos <= POS_MSB_END) begin
      bv = res[4'(POS_MSB_END - pos)];
    end else if (!cmd[FLD_ORDER] && pos <= POS_LSB_END) begin
      bv = res[4'(pos - POS_MSB_END)];
    end else if (!cmd[FLD_ORDER] && !cmd[FLD_POLARITY]) begin
      bv = res[RES_BITS-1];
    end else begin
      bv = 1'b0;
    end
    return bv;
  endfunction : bit_at

  // ****************************************************************
  // command reception and output sequencing
  // ****************************************************************
  aso_state_t          state, next_state;
  logic [2:0]          cnt, next_cnt;
  logic [6:0]          cmd_sr, next_cmd_sr;
  logic [6:0]          cmd, next_cmd;
  logic [4:0]          pos, next_pos;
  logic [RES_BITS-1:0] result, next_result;
  logic                shut, next_shut;
  logic                dout, next_dout;
  logic                start, next_start;
  logic                oe_n, next_oe_n;

  // next state of the serial sequencer
  always_comb begin
    next_state  = state;
    next_cnt    = cnt;
    next_cmd_sr = cmd_sr;
    next_cmd    = cmd;
    next_pos    = pos;
    next_result = result;
    next_shut   = shut;
    next_dout   = dout;
    next_start  = 1'b0;
    if (cs_fall) begin
      next_state = ASO_CMD;
      next_cnt   = 3'h0;
      next_shut  = 1'b0;
      next_dout  = 1'b0;
    end else if (cs_rise) begin
      next_state = ASO_IDLE;
    end else begin
      unique case (state)
        ASO_IDLE: begin
          next_cnt = 3'h0;
        end
        ASO_CMD: begin
          if (sclk_rise) begin
            if (cnt == 3'h0) begin
              next_cnt = din_lvl ? 3'h1 : 3'h0;
            end else begin
              next_cmd_sr = {cmd_sr[5:0], din_lvl};
              next_cnt    = cnt + 3'h1;
              if (cnt == CNT_LAST) begin
                next_cmd    = {cmd_sr[5:0], din_lvl};
                next_state  = ASO_DATA;
                next_pos    = POS_NULL;
                next_result = result_i;
                next_dout   = 1'b0;
                next_shut   = ~din_lvl;
                next_start  = din_lvl;
              end
            end
          end
        end
        ASO_DATA: begin
          if (sclk_fall) begin
            next_pos  = (pos == POS_FILL) ? POS_FILL : pos + 5'h01;
            next_dout = bit_at(next_pos, result, cmd, shut);
          end
        end
        default: begin
          next_state = ASO_IDLE;            // unused code falls back to idle
        end
      endcase
    end
    next_oe_n = (next_state != ASO_DATA);
  end

  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state  <= ASO_IDLE;
      cnt    <= 3'h0;
      cmd_sr <= RST_CMD;
      cmd    <= RST_CMD;
      pos    <= POS_NULL;
      result <= RST_RESULT;
      shut   <= 1'b0;
      dout   <= 1'b0;
      start  <= 1'b0;
      oe_n   <= 1'b1;
    end else begin
      state  <= next_state;
      cnt    <= next_cnt;
      cmd_sr <= next_cmd_sr;
      cmd    <= next_cmd;
      pos    <= next_pos;
      result <= next_result;
      shut   <= next_shut;
      dout   <= next_dout;
      start  <= next_start;
      oe_n   <= next_oe_n;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  // driven only while selected and past the command
  assign dout_o         = dout;
  assign dout_oe_n_o    = oe_n;
  assign shutdown_o     = shut;
  assign system_off_n_o = ~shut;
  assign conv_start_o   = start;
  assign single_ended_o = cmd[FLD_SINGLE];
  assign odd_sign_o     = cmd[FLD_ODD_SIGN];
  assign channel_sel_o  = {cmd[FLD_SEL_HI], cmd[FLD_SEL_LO]};
  assign unipolar_o     = cmd[FLD_POLARITY];

  // ****************************************************************
  // checks
  // ****************************************************************
  chk_msb_first_bits: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    (state == ASO_DATA && !shut && pos >= 5'h01 && pos <= POS_MSB_END)
      |-> dout == result[4'(POS_MSB_END - pos)])
    else $error("msb-first bit wrong");

  chk_zero_padding: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    (state == ASO_DATA && cmd[FLD_ORDER] && pos > POS_MSB_END) |-> !dout)
    else $error("pad bit not zero");

  chk_lsb_first_bits: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    (state == ASO_DATA && !shut && !cmd[FLD_ORDER] && pos > POS_MSB_END
      && pos <= POS_LSB_END) |-> dout == result[4'(pos - POS_MSB_END)])
    else $error("lsb-first bit wrong");

  chk_sign_fill: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    (state == ASO_DATA && !shut && !cmd[FLD_ORDER] && !cmd[FLD_POLARITY]
      && pos == POS_FILL) |-> dout == result[RES_BITS-1])
    else $error("sign fill wrong");

  chk_enter_shutdown: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    (state == ASO_CMD && sclk_rise && cnt == CNT_LAST && !din_lvl && !cs_fall
      && !cs_rise) |=> shut && !start)
    else $error("shutdown not entered");

  chk_ones_word: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    (state == ASO_DATA && shut && pos != POS_NULL)
      |-> dout == (pos <= POS_MSB_END))
    else $error("shutdown word wrong");

  chk_release_hiz: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    cs_rise |=> dout_oe_n_o)
    else $error("output still driven");

  chk_leave_shutdown: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    (shut && cs_fall) |=> !shut && system_off_n_o && state == ASO_CMD)
    else $error("shutdown not left");

  chk_system_off: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    ($rose(shut) |-> !system_off_n_o) and (shut && !cs_fall |=> !system_off_n_o))
    else $error("system-off output wrong");

  chk_one_bit_step: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    (state == ASO_DATA && !cs_rise && !cs_fall && !sclk_fall) |=> $stable(pos))
    else $error("stream advanced without clock");

endmodule : aso_serial

// ===== aso_sync.sv
`timescale 1ns/1ps

// ****************************************************************
// three-stage synchroniser for pin inputs
// ****************************************************************
module aso_sync #(
  parameter int W = 3
) (
  input  wire logic         clock_i,
  input  wire logic         sys_rst_i,
  input  wire logic [W-1:0] pin_i,
  output logic      [W-1:0] stage2_o,
  output logic      [W-1:0] stage3_o
);

  logic [W-1:0] stage1;

  // stage1 feeds only stage2
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      stage1   <= '0;
      stage2_o <= '0;
      stage3_o <= '0;
    end else begin
      stage1   <= pin_i;
      stage2_o <= stage1;
      stage3_o <= stage2_o;
    end
  end

endmodule : aso_sync
